// File: bench/tb_top.sv
// Bench for the serial boot loader: straps, boot set-up, baud measure,
// acknowledge, load, jump, fetch redirect and both ways out.
// Assumes the host model in ubl_host.sv.
`timescale 1ns/100ps
module tb_top;
  localparam int BIT = 64;
  localparam logic [7:0] ACK = 8'h5A; // Arbitrary value.
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sw_reset = 1'b0;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic fetch_code = 1'b0;
  logic [7:0] address = 8'h00;
  logic [15:0] write_data = 16'h0000;
  logic [23:0] fetch_address = 24'h000000;
  ubl_pkg::ubl_straps_t straps = '0;
  logic rxd, txd_pin, oe_n, wd, bmode, exec_valid, ftf;
  logic [15:0] read_data;
  logic [23:0] exec_address;
  ubl_pkg::ubl_ram_wr_t ram_wr;
  logic [7:0] exp_b [32];
  logic [15:0] ini [4] = '{16'hFA00, 16'hFA00, 16'hFA40, 16'hFC00};
  logic [23:0] fa [4] = '{24'h00FFFF, 24'h010000, 24'h08FFFF, 24'h090000};
  logic [23:0] exp_exec = 24'h00FA40;
  int error_cnt = 0, check_count = 0, nwr = 0, nexec = 0;
  wire txd_wire = oe_n ? 1'b1 : txd_pin; // Pull-up while released.

  always #5 clock = ~clock;

  ubl_loader #(.TX_DELAY(20), .ACK_BYTE(ACK)) ubl_loader_i (
    .clock(clock), .reset(reset), .sw_reset(sw_reset), .straps(straps),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .serial_receive_pin(rxd),
    .serial_transmit_pin(txd_pin), .serial_transmit_oe_n(oe_n),
    .watchdog_disable(wd), .boot_loader_mode(bmode), .ram_wr(ram_wr),
    .exec_valid(exec_valid), .exec_address(exec_address),
    .fetch_address(fetch_address), .fetch_code(fetch_code),
    .fetch_to_test_flash(ftf));
  ubl_host #(.BIT(BIT)) ubl_host_i (.clock(clock), .rxd(rxd),
    .txd(txd_wire));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    chk(read_data, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic hw_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : hw_reset
  function automatic logic [15:0] bus_exp(input ubl_pkg::ubl_straps_t s);
    return s.external_access_pin ? 16'h0000 : {8'h06, s.bus_type_field, 6'h00};
  endfunction : bus_exp
  // Integer division drops the remainder, as the device does.
  function automatic logic [15:0] reload_exp(input int b);
    return 16'((9 * b / 4 - 36) / 72);
  endfunction : reload_exp

  // Every store and every jump is checked the moment it appears.
  always @(negedge clock) begin
    if (ram_wr.write === 1'b1) begin
      chk(ram_wr.addr, 24'h00FA40 + nwr);
      chk(ram_wr.data, exp_b[nwr]);
      nwr++;
    end
    if (exec_valid === 1'b1) begin
      chk(exec_address, exp_exec);
      nexec++;
    end
  end

  // A hung sequence ends the run as a failure.
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    final_report();
  end

  initial begin
    logic [8:0] r;
    logic [31:0] s;
    s = $urandom(32'h08477DF7);
    for (int t = 0; t < 4; t++) begin
      s = $urandom;
      straps <= {1'b0, t[0], s[2:0]};
      hw_reset();
      chk({wd, bmode, oe_n}, 3'b111);
      rd(ubl_pkg::REG_SYSCFG, {6'h01, s[2], 9'h000});
      rd(ubl_pkg::REG_BUSCFG, bus_exp(straps));
      rd(ubl_pkg::REG_SERCTL, 16'h8011);
      for (int j = 0; j < 4; j++) rd(8'(16 + 4 * j), ini[j]);
    end
    fork
      ubl_host_i.send(8'h00);
      ubl_host_i.recv(r);
      begin
        repeat (585) @(posedge clock);
        chk(oe_n, 1'b1);
      end
    join
    chk(r, {1'b0, ACK});
    if (r[8]) final_report();
    chk(oe_n, 1'b0);
    rd(ubl_pkg::REG_RELOAD, reload_exp(BIT));
    repeat (128) @(posedge clock);
    for (int i = 0; i < 32; i++) begin
      exp_b[i] = 8'($urandom);
      ubl_host_i.send(exp_b[i]);
    end
    repeat (4) @(posedge clock);
    chk(nwr, 32'd32);
    chk(nexec, 32'd1);
    chk({bmode, wd}, 2'b11);
    s = $urandom;
    ubl_host_i.send(s[7:0]);
    rd(ubl_pkg::REG_RXDATA, {8'h00, s[7:0]});
    wr(ubl_pkg::REG_STKPTR, s[15:0]);
    rd(ubl_pkg::REG_STKPTR, s[15:0]);
    rd(8'h30, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      fetch_code <= i[2];
      fetch_address <= fa[i[1:0]];
      @(negedge clock);
      chk(ftf, i[2] && (i[1:0] == 1 || i[1:0] == 2));
    end
    exp_exec = 24'h000000;
    @(posedge clock);
    fetch_address <= fa[1];
    sw_reset <= 1'b1;
    @(posedge clock);
    sw_reset <= 1'b0;
    repeat (3) @(posedge clock);
    chk({bmode, oe_n, ftf}, 3'b010);
    straps <= 5'h10;
    hw_reset();
    chk(bmode, 1'b0);
    chk(nexec, 32'd3);
    final_report();
  end
endmodule : tb_top

// File: bench/ubl_host.sv
// Host model on the serial line: sends 8N1 characters, reads replies.
// Assumes the bench hands it the transmit wire with the pull-up resolved.
`timescale 1ns/100ps
module ubl_host #(
  parameter int BIT = 64
) (
  // Clock.
  input wire logic clock,
  // Serial lines.
  output logic rxd,
  input wire logic txd
);
  initial rxd = 1'b1;
  // One character, LSB first, rate matched to the device within limits.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clock);
    end
  endtask : send
  // Bounded wait for a start bit, so a silent device cannot hang us.
  task automatic recv(output logic [8:0] r);
    int n;
    n = 0;
    r = 9'h100;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        r[i] = txd;
      end
      r[8] = 1'b0;
    end
  endtask : recv
endmodule : ubl_host

// File: rtl/ubl_loader.sv
// Serial boot loader: boot entry, fixed configuration, baud measurement,
// acknowledge, 32-byte load, jump and code-fetch redirection.
// Assumes synchronous pins and a single-cycle register port master.
//
// Behaviour
// (RL1) Boot mode only when boot-select is low at hardware reset release.
// (RL2) Host opens with a zero byte: start, eight zeros, stop.
// (RL3) Boot loads context and underflow FA00, stack FA40, overflow FC00.
// (RL4) Boot sets memory enable bit 10; byte disable bit 9 from strap.
// (RL5) Bus config zero if external access high; else bits 10 and 9 set.
// (RL6) Bus type bits 7:6 follow the strap bus type.
// (RL7) Serial control gets 8011; baud reload from the zero-byte measurement.
// (RL8) Transmit latch and direction set to one so the pin drives.
// (RL9) Transmit pin driven only a delay after the zero byte.
// (RL10) Watchdog stays disabled throughout boot mode.
// (RL11) Reload equals timer count minus 36, divided by 72.
// (RL12) Baud rate is clock over 32 times reload plus one.
// (RL13) Timer overflow past full count leaves the channel unusable.
// (RL14) Host rate deviation from device rate at most 2.5 percent.
// (RL15) Host should use standard rates 1200 to 19200.
// (RL16) Thirty-two bytes stored in order at FA40 through FA5F.
// (RL17) After the last byte, execution jumps to FA40, still in boot mode.
// (RL18) Serial channel stays configured after the jump.
// (RL19) In boot mode, code fetches 010000-08FFFF go to the test flash.
// (RL20) Boot mode, watchdog off and fetch redirection persist until exit.
// (RL21) Software reset or high-strap hardware reset exits; run from 0.
// (RL22) Reload uses integer division; loading starts after the acknowledge.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ubl_loader #(
  parameter int TX_DELAY = ubl_pkg::TX_DELAY_CYCLES,
  parameter logic [7:0] ACK_BYTE = 8'h5A // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  input wire logic sw_reset,
  // Reset straps.
  input wire ubl_pkg::ubl_straps_t straps,
  // Register port.
  input wire logic [7:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  // Serial pins.
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic serial_transmit_oe_n,
  // Core side.
  output logic watchdog_disable,
  output logic boot_loader_mode,
  output ubl_pkg::ubl_ram_wr_t ram_wr,
  output logic exec_valid,
  output logic [23:0] exec_address,
  input wire logic [23:0] fetch_address,
  input wire logic fetch_code,
  output logic fetch_to_test_flash
);

  localparam int HW = $clog2(TX_DELAY + 1);

  ubl_pkg::ubl_state_t state;
  ubl_pkg::ubl_straps_t straps_q;
  logic straps_taken;
  logic [15:0] system_configuration;
  logic [15:0] bus_configuration_zero;
  logic [15:0] serial_control_register;
  logic [15:0] baud_reload_value;
  logic [15:0] context_pointer;
  logic [15:0] stack_underflow_limit;
  logic [15:0] stack_pointer;
  logic [15:0] stack_overflow_limit;
  logic transmit_port_latch, transmit_port_direction, overflow_flag, rx_full;
  logic [7:0] rx_hold;
  logic [5:0] load_count;
  logic [HW-1:0] hold_count;
  logic tx_start, meas_done, meas_overflow, tx_busy, serial_txd, rx_valid;
  logic [15:0] meas_count;
  logic [7:0] rx_data;
  wire boot_entry, hold_done, rx_data_read;
  wire [15:0] next_reload, boot_sys, boot_bus, status_word, read_mux;

  // Integer quotient; the remainder is simply dropped.
  function automatic logic [15:0] reload_of(input logic [15:0] t);
    reload_of = (t < 16'(ubl_pkg::MEAS_OFFSET)) ? 16'h0000 :
      16'((t - 16'(ubl_pkg::MEAS_OFFSET)) / 16'(ubl_pkg::MEAS_DIV));
  endfunction : reload_of

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of boot values, status and reads.
  assign boot_entry = !straps_taken && !straps.boot_select_line; // RL1
  assign hold_done = hold_count == HW'(TX_DELAY - 1); // RL9
  assign next_reload = reload_of(meas_count); // RL11
  assign boot_sys = (16'h1 << ubl_pkg::SYS_MEM_EN_BIT) // RL4
    | (16'(straps.byte_select_disable) << ubl_pkg::SYS_BYTE_DIS_BIT);
  assign boot_bus = straps.external_access_pin ? ubl_pkg::NORMAL_RESET // RL5
    : ((16'h1 << ubl_pkg::BUS_ACTIVE_BIT) | (16'h1 << ubl_pkg::BUS_ALE_BIT)
    | (16'(straps.bus_type_field) << ubl_pkg::BUS_TYPE_LSB)); // RL6
  assign status_word = {2'h0, load_count, rx_full, overflow_flag,
    transmit_port_direction, boot_loader_mode, 1'b0, state};
  assign rx_data_read = read_strobe && address == ubl_pkg::REG_RXDATA;
  assign read_mux =
    address == ubl_pkg::REG_SYSCFG ? system_configuration :
    address == ubl_pkg::REG_BUSCFG ? bus_configuration_zero :
    address == ubl_pkg::REG_SERCTL ? serial_control_register :
    address == ubl_pkg::REG_RELOAD ? baud_reload_value :
    address == ubl_pkg::REG_CONTEXT ? context_pointer :
    address == ubl_pkg::REG_STACK_UNDERFLOW_LIMIT ? stack_underflow_limit :
    address == ubl_pkg::REG_STKPTR ? stack_pointer :
    address == ubl_pkg::REG_STACK_OVERFLOW_LIMIT ? stack_overflow_limit :
    address == ubl_pkg::REG_STATUS ? status_word :
    address == ubl_pkg::REG_RXDATA ? {8'h00, rx_hold} : 16'h0000;

  // The watchdog simply follows boot mode, so no sequence is time limited.
  assign watchdog_disable = boot_loader_mode; // RL10 RL20
  assign fetch_to_test_flash = boot_loader_mode && fetch_code // RL19
    && fetch_address >= ubl_pkg::FLASH_LOW
    && fetch_address <= ubl_pkg::FLASH_HIGH;
  // The pin floats until the direction bit is set; it then idles high.
  assign serial_transmit_oe_n = !transmit_port_direction; // RL8
  assign serial_transmit_pin = transmit_port_latch && serial_txd;

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) read_data <= 16'h0000;
    else read_data <= read_strobe ? read_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequence and register file. Hardware events win over software
  // writes to the same register in the same cycle.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ubl_pkg::ST_NORMAL;
      straps_q <= '0;
      straps_taken <= 1'b0;
      boot_loader_mode <= 1'b0;
      system_configuration <= ubl_pkg::NORMAL_RESET;
      bus_configuration_zero <= ubl_pkg::NORMAL_RESET;
      serial_control_register <= ubl_pkg::NORMAL_RESET;
      baud_reload_value <= ubl_pkg::NORMAL_RESET;
      context_pointer <= ubl_pkg::NORMAL_RESET;
      stack_underflow_limit <= ubl_pkg::NORMAL_RESET;
      stack_pointer <= ubl_pkg::NORMAL_RESET;
      stack_overflow_limit <= ubl_pkg::NORMAL_RESET;
      transmit_port_latch <= 1'b0;
      transmit_port_direction <= 1'b0;
      overflow_flag <= 1'b0;
      rx_full <= 1'b0;
      rx_hold <= 8'h00;
      load_count <= 6'h00;
      hold_count <= '0;
      tx_start <= 1'b0;
      ram_wr <= '0;
      exec_valid <= 1'b0;
      exec_address <= ubl_pkg::EXEC_RESET;
    end else begin
      tx_start <= 1'b0;
      ram_wr.write <= 1'b0;
      exec_valid <= 1'b0;
      if (write_strobe) begin
        unique case (address)
          ubl_pkg::REG_SYSCFG: system_configuration <= write_data;
          ubl_pkg::REG_BUSCFG: bus_configuration_zero <= write_data;
          ubl_pkg::REG_SERCTL: serial_control_register <= write_data;
          ubl_pkg::REG_RELOAD: baud_reload_value <= write_data;
          ubl_pkg::REG_CONTEXT: context_pointer <= write_data;
          ubl_pkg::REG_STACK_UNDERFLOW_LIMIT: stack_underflow_limit <= write_data;
          ubl_pkg::REG_STKPTR: stack_pointer <= write_data;
          ubl_pkg::REG_STACK_OVERFLOW_LIMIT: stack_overflow_limit <= write_data;
          default: ;
        endcase
      end
      // A byte arriving as the holding register is read keeps it full.
      if (rx_data_read) rx_full <= 1'b0;
      if (!straps_taken) begin
        straps_taken <= 1'b1;
        straps_q <= straps;
        exec_valid <= !boot_entry;
        if (boot_entry) begin
          boot_loader_mode <= 1'b1; // RL1
          state <= ubl_pkg::ST_MEASURE;
          system_configuration <= boot_sys; // RL4
          bus_configuration_zero <= boot_bus; // RL5 RL6
          serial_control_register <= ubl_pkg::SERIAL_CTRL_INIT; // RL7
          context_pointer <= ubl_pkg::CONTEXT_INIT; // RL3
          stack_underflow_limit <= ubl_pkg::STACK_UNDER_INIT; // RL3
          stack_pointer <= ubl_pkg::STACK_PTR_INIT; // RL3
          stack_overflow_limit <= ubl_pkg::STACK_OVER_INIT; // RL3
        end
      end else if (sw_reset) begin
        // Exit ignores the strap and restarts at the reset vector.
        boot_loader_mode <= 1'b0; // RL21
        state <= ubl_pkg::ST_NORMAL;
        system_configuration <= ubl_pkg::NORMAL_RESET;
        bus_configuration_zero <= ubl_pkg::NORMAL_RESET;
        serial_control_register <= ubl_pkg::NORMAL_RESET;
        baud_reload_value <= ubl_pkg::NORMAL_RESET;
        transmit_port_latch <= 1'b0;
        transmit_port_direction <= 1'b0;
        exec_valid <= 1'b1; // RL21
        exec_address <= ubl_pkg::EXEC_RESET;
      end else begin
        unique case (state)
          ubl_pkg::ST_NORMAL, ubl_pkg::ST_FAIL: ;
          ubl_pkg::ST_MEASURE: begin
            if (meas_overflow) begin
              overflow_flag <= 1'b1; // RL13
              state <= ubl_pkg::ST_FAIL;
            end else if (meas_done) begin
              baud_reload_value <= next_reload; // RL7 RL22
              hold_count <= '0;
              state <= ubl_pkg::ST_HOLD;
            end
          end
          ubl_pkg::ST_HOLD: begin
            hold_count <= hold_count + HW'(1);
            if (hold_done) begin
              transmit_port_latch <= 1'b1; // RL8
              transmit_port_direction <= 1'b1; // RL8
              tx_start <= 1'b1;
              state <= ubl_pkg::ST_ACK;
            end
          end
          ubl_pkg::ST_ACK: begin
            if (!tx_start && !tx_busy) state <= ubl_pkg::ST_LOAD; // RL22
          end
          ubl_pkg::ST_LOAD: begin
            if (rx_valid) begin
              ram_wr.write <= 1'b1; // RL16
              ram_wr.addr <= ubl_pkg::LOAD_BASE + 24'(load_count);
              ram_wr.data <= rx_data;
              load_count <= load_count + 6'h01;
              if (load_count == ubl_pkg::LOAD_BYTES - 6'h01) begin
                exec_valid <= 1'b1; // RL17
                exec_address <= ubl_pkg::LOAD_BASE;
                state <= ubl_pkg::ST_RUN;
              end
            end
          end
          ubl_pkg::ST_RUN: begin
            if (rx_valid) begin
              rx_hold <= rx_data; // RL18
              rx_full <= 1'b1;
            end
          end
          default: state <= ubl_pkg::ST_FAIL;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-byte timer and serial channel.
  ubl_measure u_measure (
    .clock(clock),
    .reset(reset),
    .arm(state == ubl_pkg::ST_MEASURE),
    .rxd(serial_receive_pin),
    .done(meas_done),
    .overflow(meas_overflow),
    .count(meas_count)
  );

  ubl_serial u_serial (
    .clock(clock),
    .reset(reset),
    .enable(serial_control_register[ubl_pkg::SERIAL_RUN_BIT]),
    .reload(baud_reload_value),
    .tx_start(tx_start),
    .tx_data(ACK_BYTE),
    .tx_busy(tx_busy),
    .txd(serial_txd),
    .rx_enable(state == ubl_pkg::ST_LOAD || state == ubl_pkg::ST_RUN),
    .rxd(serial_receive_pin),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  boot_entry_a: assert property ($rose(straps_taken) |-> // RL1
    boot_loader_mode == !straps_q.boot_select_line)
    else $error("boot mode does not follow the strap");
  stack_init_a: assert property ($rose(boot_loader_mode) |-> // RL3
    context_pointer == 16'hFA00 && stack_pointer == 16'hFA40
    && stack_underflow_limit == 16'hFA00 && stack_overflow_limit == 16'hFC00)
    else $error("stack setup wrong at boot entry");
  sys_config_a: assert property ($rose(boot_loader_mode) |-> // RL4
    system_configuration[10] && system_configuration[9]
    == straps_q.byte_select_disable)
    else $error("system configuration wrong at boot entry");
  bus_access_a: assert property ($rose(boot_loader_mode) // RL5
    && straps_q.external_access_pin |-> bus_configuration_zero == 16'h0000)
    else $error("bus config not cleared");
  bus_type_a: assert property ($rose(boot_loader_mode) // RL6
    && !straps_q.external_access_pin |-> bus_configuration_zero
    == {8'h06, straps_q.bus_type_field, 6'h00})
    else $error("bus config wrong with external access");
  reload_calc_a: assert property (state == ubl_pkg::ST_MEASURE // RL11
    && meas_done && !sw_reset |=> baud_reload_value == ($past(meas_count)
    < 16'd36 ? 16'h0000 : ($past(meas_count) - 16'd36) / 16'd72))
    else $error("baud reload wrong");
  tx_quiet_a: assert property (state == ubl_pkg::ST_MEASURE // RL9
    |-> serial_transmit_oe_n ##1 serial_transmit_oe_n)
    else $error("transmit driven before delay");
  watchdog_off_a: assert property (state != ubl_pkg::ST_NORMAL // RL10
    |-> watchdog_disable)
    else $error("watchdog enabled in boot");
  load_range_a: assert property (ram_wr.write // RL16
    |-> ram_wr.addr >= 24'h00FA40 && ram_wr.addr <= 24'h00FA5F
    && state inside {ubl_pkg::ST_LOAD, ubl_pkg::ST_RUN})
    else $error("load address out of range");
  jump_a: assert property (state == ubl_pkg::ST_LOAD && rx_valid // RL17
    && load_count == 6'd31 && !sw_reset |=> exec_valid
    && exec_address == 24'h00FA40 && boot_loader_mode)
    else $error("no jump after last byte");
  redirect_a: assert property (!boot_loader_mode // RL19
    |-> !fetch_to_test_flash) else $error("fetch redirected outside boot");
  exit_a: assert property (sw_reset && straps_taken // RL21
    |=> !boot_loader_mode && exec_valid && exec_address == 24'h000000)
    else $error("software reset did not exit boot");
  ack_first_a: assert property (state == ubl_pkg::ST_LOAD |-> !tx_busy) // RL22
    else $error("loading while acknowledge in flight");

  boot_seen_c: cover property ($rose(boot_loader_mode));
  load_done_c: cover property (state == ubl_pkg::ST_LOAD
    ##1 state == ubl_pkg::ST_RUN);
  overflow_c: cover property ($rose(overflow_flag));

endmodule : ubl_loader

// File: rtl/ubl_measure.sv
// Zero-byte length timer of the serial boot loader.
// Assumes the receive line is synchronous and idles high.
`timescale 1ns/100ps
module ubl_measure (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Control and line.
  input wire logic arm,
  input wire logic rxd,
  // Result.
  output logic done,
  output logic overflow,
  output logic [15:0] count
);

  logic [1:0] prescale;
  logic low_seen;
  wire tick;

  // The timer advances once per four clocks, as the measuring timer does.
  assign tick = prescale == 2'(ubl_pkg::TIMER_PRESCALE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Count while the line is low; the rise back to high ends the byte.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prescale <= 2'h0;
      low_seen <= 1'b0;
      count <= 16'h0000;
      done <= 1'b0;
      overflow <= 1'b0;
    end else if (!arm) begin
      prescale <= 2'h0;
      low_seen <= 1'b0;
      count <= 16'h0000;
      done <= 1'b0;
      overflow <= 1'b0;
    end else begin
      done <= 1'b0;
      overflow <= 1'b0;
      if (!rxd) begin
        low_seen <= 1'b1;
        prescale <= prescale + 2'h1;
        if (tick) begin
          // A full count cannot hold the byte, so the result is void.
          if (count == 16'hFFFF) overflow <= 1'b1; // RL13
          else count <= count + 16'h0001; // RL11
        end
      end else if (low_seen) begin
        done <= 1'b1;
        low_seen <= 1'b0;
      end
    end
  end

endmodule : ubl_measure

// File: rtl/ubl_pkg.sv
// Shared constants, states and carriers of the serial boot loader.
// Assumes a single 100 MHz clock and a 16-bit register port.
package ubl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLOCK_HZ = 100_000_000;
  localparam int TX_DELAY_US = 1300;
  localparam int TX_DELAY_CYCLES = TX_DELAY_US * (CLOCK_HZ / 1_000_000);
  localparam int TIMER_PRESCALE = 4;
  localparam int MEAS_OFFSET = 36;
  localparam int MEAS_DIV = 72;
  localparam int BIT_SHIFT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Boot configuration values and field positions.
  localparam logic [15:0] CONTEXT_INIT = 16'hFA00;
  localparam logic [15:0] STACK_UNDER_INIT = 16'hFA00;
  localparam logic [15:0] STACK_PTR_INIT = 16'hFA40;
  localparam logic [15:0] STACK_OVER_INIT = 16'hFC00;
  localparam logic [15:0] SERIAL_CTRL_INIT = 16'h8011;
  localparam logic [15:0] NORMAL_RESET = 16'h0000;
  localparam int SYS_MEM_EN_BIT = 10;
  localparam int SYS_BYTE_DIS_BIT = 9;
  localparam int BUS_ACTIVE_BIT = 10;
  localparam int BUS_ALE_BIT = 9;
  localparam int BUS_TYPE_LSB = 6;
  localparam int SERIAL_RUN_BIT = 15;
  localparam logic [5:0] LOAD_BYTES = 6'h20;
  localparam logic [23:0] LOAD_BASE = 24'h00FA40;
  localparam logic [23:0] EXEC_RESET = 24'h000000;
  localparam logic [23:0] FLASH_LOW = 24'h010000;
  localparam logic [23:0] FLASH_HIGH = 24'h08FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] REG_SYSCFG = 8'h00;
  localparam logic [7:0] REG_BUSCFG = 8'h04;
  localparam logic [7:0] REG_SERCTL = 8'h08;
  localparam logic [7:0] REG_RELOAD = 8'h0C;
  localparam logic [7:0] REG_CONTEXT = 8'h10;
  localparam logic [7:0] REG_STACK_UNDERFLOW_LIMIT = 8'h14;
  localparam logic [7:0] REG_STKPTR = 8'h18;
  localparam logic [7:0] REG_STACK_OVERFLOW_LIMIT = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_RXDATA = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // States and carriers.
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_MEASURE = 3'b001,
    ST_HOLD = 3'b010,
    ST_ACK = 3'b011,
    ST_LOAD = 3'b100,
    ST_RUN = 3'b101,
    ST_FAIL = 3'b110
  } ubl_state_t;

  typedef struct packed {
    logic boot_select_line;
    logic external_access_pin;
    logic byte_select_disable;
    logic [1:0] bus_type_field;
  } ubl_straps_t;

  typedef struct packed {
    logic write;
    logic [23:0] addr;
    logic [7:0] data;
  } ubl_ram_wr_t;

endpackage : ubl_pkg

// File: rtl/ubl_serial.sv
// Asynchronous serial channel, eight data bits, one stop bit.
// Assumes the reload value is stable while a character is in flight.
`timescale 1ns/100ps
module ubl_serial (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Configuration.
  input wire logic enable,
  input wire logic [15:0] reload,
  // Transmit side.
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic txd,
  // Receive side.
  input wire logic rx_enable,
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data
);

  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [21:0] tx_timer;
  logic [3:0] rx_bits;
  logic [21:0] rx_timer;
  wire [21:0] period;

  // One bit lasts 32 clocks per reload step.
  assign period = (22'(reload) + 22'h1) << ubl_pkg::BIT_SHIFT; // RL12
  assign tx_busy = tx_bits != 4'h0;
  assign txd = tx_shift[0];

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: start bit, data LSB first, stop bit.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_shift <= 10'h3FF;
      tx_bits <= 4'h0;
      tx_timer <= 22'h0;
    end else if (tx_start && !tx_busy && enable) begin
      tx_shift <= {1'b1, tx_data, 1'b0};
      tx_bits <= 4'hA;
      tx_timer <= period;
    end else if (tx_busy) begin
      if (tx_timer == 22'h1) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits <= tx_bits - 4'h1;
        tx_timer <= period;
      end else begin
        tx_timer <= tx_timer - 22'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver samples mid-bit; a start bit gone high by then is a glitch.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_bits <= 4'h0;
      rx_timer <= 22'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_bits == 4'h0) begin
        if (rx_enable && enable && !rxd) begin
          rx_bits <= 4'hA;
          rx_timer <= period >> 1;
        end
      end else if (rx_timer > 22'h1) begin
        rx_timer <= rx_timer - 22'h1;
      end else begin
        rx_timer <= period;
        rx_bits <= rx_bits - 4'h1;
        if (rx_bits == 4'hA && rxd) rx_bits <= 4'h0;
        else if (rx_bits > 4'h1 && rx_bits < 4'hA)
          rx_data <= {rxd, rx_data[7:1]};
        else if (rx_bits == 4'h1) rx_valid <= rxd;
      end
    end
  end

endmodule : ubl_serial
